// >>> pkg/stl_consts.vh
// constants for the software trap and bus lock unit
`ifndef STL_CONSTS_VH
`define STL_CONSTS_VH
// decoded command codes
`define STL_OP_TRAP_FIXED  4'h0
`define STL_OP_TRAP_IMM    4'h1
`define STL_OP_EMU_ENTRY   4'h2
`define STL_OP_OVF_TRAP    4'h3
`define STL_OP_EXT_ENTRY   4'h4
`define STL_OP_LOCK        4'h5
`define STL_OP_OVF_BRANCH  4'h6
`define STL_OP_EMU_RET     4'h7
`define STL_OP_NAT_CALL    4'h8
`define STL_OP_EXT_RET     4'h9
`define STL_OP_INT_RET     4'ha
// fixed vectors
`define STL_VEC_FIXED  8'h03
`define STL_VEC_OVF    8'h04
// flag word bit positions
`define STL_FLAG_STEP   8
`define STL_FLAG_INTEN  9
`define STL_FLAG_OVF    11
`define STL_FLAG_NATIVE 15
// extended address mode control register
`define STL_EAMC_ADDR    16'hff80
`define STL_EAMC_EXT_BIT 0
`define STL_EAMC_RST     8'h00
// stack step and vector word offsets
`define STL_SP_STEP   16'h0002
`define STL_VEC_HI    16'h0002
`endif

// >>> rtl/stl_bus_if.v
// single memory access handshake for the trap unit
`timescale 1ns/1ps
module stl_bus_if #(
	parameter AW = 20
) (
	input  wire          clk_sys,
	input  wire          resetn,
	input  wire          ce,
	input  wire          start,
	input  wire          we,
	input  wire [AW-1:0] addr,
	input  wire [15:0]   wdata,
	input  wire          ext,
	output wire          busy,
	output wire          done,
	output reg           mem_req,
	output reg           mem_we,
	output reg  [AW-1:0] mem_addr,
	output reg  [15:0]   mem_wdata,
	output reg           mem_ext,
	input  wire          mem_ack
);
	assign busy = mem_req;
	// ack only counts while a request stands and the clock is enabled
	assign done = mem_req & mem_ack & ce;

	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			mem_req   <= 1'b0;
			mem_we    <= 1'b0;
			mem_addr  <= {AW{1'b0}};
			mem_wdata <= 16'h0000;
			mem_ext   <= 1'b0;
		end else if (ce) begin
			if (start && !mem_req) begin
				mem_req   <= 1'b1;
				mem_we    <= we;
				mem_addr  <= addr;
				mem_wdata <= wdata;
				mem_ext   <= ext;
			end else if (mem_req && mem_ack) begin
				mem_req <= 1'b0;
				mem_we  <= 1'b0;
			end
		end
	end
endmodule

// >>> rtl/stl_lock_ctl.v
// bus lock window and hold refusal
`timescale 1ns/1ps
module stl_lock_ctl (
	input  wire clk_sys,
	input  wire resetn,
	input  wire ce,
	input  wire prefix,
	input  wire instr_done,
	input  wire rep_busy,
	input  wire small_mode,
	input  wire hold_req,
	output wire hold_grant,
	output wire bus_lock_n,
	output wire int_inhibit
);
	reg arm_q;
	reg arm_d;

	// RULE13: lock spans next instruction
	always @* begin
		arm_d = arm_q;
		if (prefix)
			arm_d = 1'b1;
		// RULE14: held until repeats finish
		else if (arm_q && instr_done && !rep_busy)
			arm_d = 1'b0;
	end

	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			arm_q <= 1'b0;
		else if (ce)
			arm_q <= arm_d;
	end

	// RULE15: small mode refuses hold instead
	assign bus_lock_n  = ~(arm_q & ~small_mode);
	assign hold_grant  = hold_req & ~(arm_q & small_mode);
	// RULE16: no interrupts or step break inside
	assign int_inhibit = arm_q;
endmodule

// >>> rtl/stl_trap_unit.v
// software trap, emulation entry, extended address entry, bus lock and overflow branch
//
// What the document requires
// RULE1: trap pushes flags, clears enables, pushes segment, counter
// RULE2: one-byte trap uses vector 3
// RULE3: imm8 trap vector at number times four
// RULE4: emulation entry pushes state, clears mode flag
// RULE5: emulation decode until return or native call
// RULE6: overflow set traps through vector 4
// RULE7: overflow clear just falls through
// RULE8: extended entry jumps, sets flag at FF80H
// RULE9: normal mode reads vector, then sets flag
// RULE10: extended mode reads vector with extended addressing
// RULE11: extended entry pushes nothing
// RULE12: only extended return clears extended flag
// RULE13: lock prefix locks next instruction
// RULE14: lock held across all repetitions
// RULE15: small mode refuses hold, no lock pin
// RULE16: no interrupts between prefix and instruction
// RULE17: software avoids lock before test-wait instruction
// RULE18: overflow branch adds signed 8-bit displacement
// RULE19: arithmetic flags never changed
`timescale 1ns/1ps
`include "stl_consts.vh"
module stl_trap_unit #(
	parameter AW = 20
) (
	input  wire          clk_sys,
	input  wire          resetn,
	input  wire          ce,
	input  wire          cmd_valid,
	input  wire [3:0]    cmd_op,
	input  wire [7:0]    cmd_imm,
	output wire          cmd_ready,
	input  wire [15:0]   pc_in,
	input  wire [15:0]   seg_in,
	input  wire [15:0]   ss_in,
	input  wire [15:0]   sp_in,
	input  wire [15:0]   psw_in,
	output reg           upd_valid,
	output reg  [15:0]   pc_out,
	output reg  [15:0]   seg_out,
	output reg  [15:0]   sp_out,
	output reg  [15:0]   psw_out,
	output wire          emu_mode,
	output wire          ext_addr_mode,
	output wire          mem_req,
	output wire          mem_we,
	output wire [AW-1:0] mem_addr,
	output wire [15:0]   mem_wdata,
	output wire          mem_ext,
	input  wire          mem_ack,
	input  wire [15:0]   mem_rdata,
	input  wire          io_wr,
	input  wire          io_rd,
	input  wire [15:0]   io_addr,
	input  wire [7:0]    io_wdata,
	output reg  [7:0]    io_rdata,
	input  wire          instr_done,
	input  wire          rep_busy,
	input  wire          small_mode,
	input  wire          hold_req,
	output wire          hold_grant,
	output wire          bus_lock_n,
	output wire          int_inhibit
);
	localparam S_IDLE = 3'd0;
	localparam S_VLO  = 3'd1;
	localparam S_VHI  = 3'd2;
	localparam S_PSW  = 3'd3;
	localparam S_SEG  = 3'd4;
	localparam S_PC   = 3'd5;

	reg  [2:0]    st_q;
	reg  [2:0]    st_d;
	reg  [3:0]    op_q;
	reg  [7:0]    vec_q;
	reg  [15:0]   tmp_off_q;
	reg  [15:0]   tmp_seg_q;
	reg  [15:0]   pc_q;
	reg  [15:0]   seg_q;
	reg  [15:0]   ss_q;
	reg  [15:0]   sp_q;
	reg  [15:0]   psw_q;
	reg           native_q;
	reg           ext_addr_q;
	reg           vext_q;
	reg           bus_we;
	reg  [AW-1:0] bus_addr;
	reg  [15:0]   bus_wdata;
	wire          bus_busy;
	wire          bus_done;
	wire          bus_start;
	wire          take;
	wire          lock_pulse;
	wire [15:0]   sp_dec;
	wire [15:0]   disp;
	wire [15:0]   vec_off;

	// physical address from segment and offset
	function [AW-1:0] phys;
		input [15:0] seg;
		input [15:0] off;
		reg   [19:0] sum;
		begin
			sum  = {seg, 4'h0} + {4'h0, off};
			phys = sum[AW-1:0];
		end
	endfunction

	assign cmd_ready  = (st_q == S_IDLE);
	assign take       = cmd_valid & cmd_ready & ce;
	assign lock_pulse = take & (cmd_op == `STL_OP_LOCK);
	assign sp_dec     = sp_q - `STL_SP_STEP;
	// RULE3: vector slot is number times four
	assign vec_off    = {6'h00, vec_q, 2'b00};
	// RULE18: sign-extend the displacement
	assign disp       = {{8{cmd_imm[7]}}, cmd_imm};
	assign bus_start  = (st_q != S_IDLE) & ~bus_busy;
	// RULE5: native flag low means emulation decode
	assign emu_mode      = ~native_q;
	assign ext_addr_mode = ext_addr_q;

	// bus request for the current step
	always @* begin
		bus_we    = 1'b1;
		bus_addr  = phys(ss_q, sp_dec);
		bus_wdata = psw_q;
		case (st_q)
			S_VLO: begin
				bus_we   = 1'b0;
				bus_addr = phys(16'h0000, vec_off);
			end
			S_VHI: begin
				bus_we   = 1'b0;
				bus_addr = phys(16'h0000, vec_off + `STL_VEC_HI);
			end
			S_SEG:
				bus_wdata = seg_q;
			S_PC:
				bus_wdata = pc_q;
			default:
				bus_wdata = psw_q;
		endcase
	end

	// step sequence
	always @* begin
		st_d = st_q;
		case (st_q)
			S_IDLE: begin
				if (take) begin
					if (cmd_op == `STL_OP_TRAP_FIXED || cmd_op == `STL_OP_TRAP_IMM ||
						cmd_op == `STL_OP_EMU_ENTRY || cmd_op == `STL_OP_EXT_ENTRY ||
						cmd_op == `STL_OP_NAT_CALL)
						st_d = S_VLO;
					// RULE6: only trap on overflow set
					else if (cmd_op == `STL_OP_OVF_TRAP && psw_in[`STL_FLAG_OVF])
						st_d = S_VLO;
				end
			end
			S_VLO:
				if (bus_done)
					st_d = S_VHI;
			S_VHI: begin
				// RULE11: extended entry skips every push
				if (bus_done)
					st_d = (op_q == `STL_OP_EXT_ENTRY) ? S_IDLE : S_PSW;
			end
			S_PSW:
				if (bus_done)
					st_d = S_SEG;
			S_SEG:
				if (bus_done)
					st_d = S_PC;
			S_PC:
				if (bus_done)
					st_d = S_IDLE;
			default:
				st_d = S_IDLE;
		endcase
	end

	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st_q      <= S_IDLE;
			op_q      <= 4'h0;
			vec_q     <= 8'h00;
			tmp_off_q  <= 16'h0000;
			tmp_seg_q  <= 16'h0000;
			pc_q       <= 16'h0000;
			seg_q      <= 16'h0000;
			ss_q       <= 16'h0000;
			sp_q       <= 16'h0000;
			psw_q      <= 16'h0000;
			native_q   <= 1'b1;
			ext_addr_q <= 1'b0;
			vext_q     <= 1'b0;
			upd_valid  <= 1'b0;
			pc_out     <= 16'h0000;
			seg_out    <= 16'h0000;
			sp_out    <= 16'h0000;
			psw_out   <= 16'h0000;
			io_rdata  <= 8'h00;
		end else if (ce) begin
			st_q      <= st_d;
			upd_valid <= 1'b0;
			if (io_rd && io_addr == `STL_EAMC_ADDR)
				io_rdata <= {7'h00, ext_addr_q};
			if (take) begin
				op_q   <= cmd_op;
				pc_q   <= pc_in;
				seg_q  <= seg_in;
				ss_q   <= ss_in;
				sp_q   <= sp_in;
				psw_q  <= psw_in;
				// RULE9: vector read uses the mode at entry
				// RULE10: already extended means extended read
				vext_q <= ext_addr_q;
				pc_out <= pc_in;
				seg_out <= seg_in;
				sp_out <= sp_in;
				// RULE19: arithmetic flags pass through untouched
				psw_out <= psw_in;
				// RULE2: one-byte form uses vector 3
				if (cmd_op == `STL_OP_TRAP_FIXED)
					vec_q <= `STL_VEC_FIXED;
				else if (cmd_op == `STL_OP_OVF_TRAP)
					vec_q <= `STL_VEC_OVF;
				else
					vec_q <= cmd_imm;
				case (cmd_op)
					`STL_OP_OVF_BRANCH: begin
						upd_valid <= 1'b1;
						// RULE18: branch only on overflow set
						if (psw_in[`STL_FLAG_OVF])
							pc_out <= pc_in + disp;
					end
					`STL_OP_OVF_TRAP:
						// RULE7: overflow clear falls through
						upd_valid <= ~psw_in[`STL_FLAG_OVF];
					`STL_OP_EMU_RET: begin
						// RULE5: return to native decode
						native_q  <= 1'b1;
						upd_valid <= 1'b1;
					end
					`STL_OP_EXT_RET: begin
						// RULE12: dedicated return clears the flag
						ext_addr_q <= 1'b0;
						upd_valid  <= 1'b1;
					end
					`STL_OP_LOCK, `STL_OP_INT_RET:
						upd_valid <= 1'b1;
					default:
						upd_valid <= 1'b0;
				endcase
			end
			if (bus_done) begin
				case (st_q)
					S_VLO:
						tmp_off_q <= mem_rdata;
					S_VHI: begin
						tmp_seg_q <= mem_rdata;
						if (op_q == `STL_OP_EXT_ENTRY) begin
							// RULE8: jump and set the flag in the same cycle
							ext_addr_q <= 1'b1;
							pc_out     <= tmp_off_q;
							seg_out    <= mem_rdata;
							upd_valid  <= 1'b1;
						end
					end
					S_PSW: begin
						// RULE1: flags pushed first, then cleared
						sp_q <= sp_dec;
						if (op_q == `STL_OP_EMU_ENTRY) begin
							// RULE4: emulation entry clears mode flag
							native_q <= 1'b0;
							psw_out[`STL_FLAG_NATIVE] <= 1'b0;
						end else if (op_q == `STL_OP_NAT_CALL) begin
							native_q <= 1'b1;
							psw_out[`STL_FLAG_NATIVE] <= 1'b1;
						end else begin
							psw_out[`STL_FLAG_INTEN] <= 1'b0;
							psw_out[`STL_FLAG_STEP]  <= 1'b0;
						end
					end
					S_SEG:
						// RULE1: segment base pushed second
						sp_q <= sp_dec;
					S_PC: begin
						// RULE1: program counter pushed last
						sp_q      <= sp_dec;
						sp_out    <= sp_dec;
						pc_out    <= tmp_off_q;
						seg_out   <= tmp_seg_q;
						upd_valid <= 1'b1;
					end
					default:
						sp_q <= sp_q;
				endcase
			end
			// RULE12: software may set but never clear the flag here
			// placed last so a set wins over a clear in the same cycle
			if (io_wr && io_addr == `STL_EAMC_ADDR && io_wdata[`STL_EAMC_EXT_BIT])
				ext_addr_q <= 1'b1;
		end
	end

	// one access at a time keeps ordering of pushes obvious
	stl_bus_if #(
		.AW (AW)
	) u_bus (
		.clk_sys   (clk_sys),
		.resetn    (resetn),
		.ce        (ce),
		.start     (bus_start),
		.we        (bus_we),
		.addr      (bus_addr),
		.wdata     (bus_wdata),
		.ext       (vext_q),
		.busy      (bus_busy),
		.done      (bus_done),
		.mem_req   (mem_req),
		.mem_we    (mem_we),
		.mem_addr  (mem_addr),
		.mem_wdata (mem_wdata),
		.mem_ext   (mem_ext),
		.mem_ack   (mem_ack)
	);

	stl_lock_ctl u_lock (
		.clk_sys     (clk_sys),
		.resetn      (resetn),
		.ce          (ce),
		.prefix      (lock_pulse),
		.instr_done  (instr_done),
		.rep_busy    (rep_busy),
		.small_mode  (small_mode),
		.hold_req    (hold_req),
		.hold_grant  (hold_grant),
		.bus_lock_n  (bus_lock_n),
		.int_inhibit (int_inhibit)
	);
endmodule

// >>> tb/stl_mem_model.sv
// memory bus partner for the trap unit
`timescale 1ns/1ps
module stl_mem_model (
	input  wire         clk_sys,
	input  wire         mem_req,
	input  wire         mem_we,
	input  wire  [19:0] mem_addr,
	input  wire  [15:0] mem_wdata,
	input  wire         mem_ext,
	input  wire  [1:0]  lat,
	output logic        mem_ack,
	output logic [15:0] mem_rdata
);
	logic [1:0]  wait_q;
	logic        ext_q;
	logic [35:0] wr_log[$];
	initial begin
		{mem_ack, wait_q, ext_q} = '0;
		mem_rdata = 16'h0000;
	end
	// read data toggles off the ack so stale values never pass
	always @(posedge clk_sys) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_req && mem_ack) begin
			ext_q <= mem_ext;
			if (mem_we)
				wr_log.push_back({mem_addr, mem_wdata});
		end else if (mem_req && wait_q == lat) begin
			wait_q <= 2'h0;
			mem_ack <= 1'b1;
			mem_rdata <= mem_addr[15:0] ^ 16'h5a5a;
		end else if (mem_req) begin
			wait_q <= wait_q + 2'h1;
		end
	end
endmodule

// >>> tb/stl_trap_unit_assertions.sv
// port checker for the trap unit
`timescale 1ns/1ps
`include "stl_consts.vh"
module stl_trap_unit_assertions (
	input wire        clk_sys,
	input wire        resetn,
	input wire        ce,
	input wire        cmd_valid,
	input wire [3:0]  cmd_op,
	input wire [7:0]  cmd_imm,
	input wire        cmd_ready,
	input wire [15:0] pc_in,
	input wire [15:0] psw_in,
	input wire        upd_valid,
	input wire [15:0] pc_out,
	input wire [15:0] psw_out,
	input wire        ext_addr_mode,
	input wire        mem_req,
	input wire        mem_we,
	input wire        instr_done,
	input wire        rep_busy,
	input wire        small_mode,
	input wire        hold_req,
	input wire        hold_grant,
	input wire        bus_lock_n
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	wire        tk = cmd_valid & cmd_ready & ce;
	wire        lk = tk && cmd_op == `STL_OP_LOCK;
	wire [15:0] br_tgt = pc_in + {{8{cmd_imm[7]}}, cmd_imm};
	reg         ext_seq_q;
	reg  [15:0] psw_t_q;
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ext_seq_q <= 1'b0;
			psw_t_q <= 16'h0000;
		end else if (tk) begin
			ext_seq_q <= (cmd_op == `STL_OP_EXT_ENTRY);
			psw_t_q <= psw_in;
		end else if (upd_valid) begin
			ext_seq_q <= 1'b0;
		end
	end
	lock_pin_a: assert property (
		lk && !small_mode |=> !bus_lock_n) else $error("lock not asserted");
	lock_rep_a: assert property (
		!bus_lock_n |=> bus_lock_n == $past(instr_done && !rep_busy)) else $error("lock span wrong");
	small_pin_a: assert property (
		small_mode |-> bus_lock_n) else $error("lock pin driven in small mode");
	small_hold_a: assert property (
		lk && small_mode && hold_req |=> !hold_grant) else $error("hold granted while locked");
	ext_keep_a: assert property (
		ext_addr_mode && !(tk && cmd_op == `STL_OP_EXT_RET) |=> ext_addr_mode)
		else $error("extended flag dropped");
	ext_push_a: assert property (
		ext_seq_q && mem_req |-> !mem_we) else $error("extended entry wrote memory");
	ext_set_a: assert property (
		ext_seq_q && upd_valid |=> ext_addr_mode) else $error("extended flag not set");
	br_pc_a: assert property (
		tk && cmd_op == `STL_OP_OVF_BRANCH && psw_in[`STL_FLAG_OVF]
		|=> upd_valid && pc_out == $past(br_tgt))
		else $error("branch target wrong");
	ovf_skip_a: assert property (
		tk && cmd_op == `STL_OP_OVF_TRAP && !psw_in[`STL_FLAG_OVF]
		|=> upd_valid && pc_out == $past(pc_in))
		else $error("overflow trap not skipped");
	flag_keep_a: assert property (
		upd_valid |-> (psw_out & 16'h08d5) == (psw_t_q & 16'h08d5)) else $error("flags changed");
	trap_c: cover property (tk && cmd_op == `STL_OP_TRAP_FIXED);
	rep_c: cover property (!bus_lock_n && rep_busy && instr_done);
	ext_c: cover property (ext_seq_q && upd_valid);
endmodule

// >>> tb/stl_trap_unit_bench.sv
// self-checking bench for the trap unit
`timescale 1ns/1ps
`include "stl_consts.vh"
module stl_trap_unit_bench;
	logic        clk_sys, resetn, ce, cmd_valid, cmd_ready, upd_valid, emu_mode, ext_addr_mode;
	logic        mem_req, mem_we, mem_ext, mem_ack, io_wr, io_rd, instr_done, rep_busy;
	logic        small_mode, hold_req, hold_grant, bus_lock_n, int_inhibit;
	logic [3:0]  cmd_op;
	logic [7:0]  cmd_imm, io_wdata, io_rdata;
	logic [15:0] pc_in, seg_in, ss_in, sp_in, psw_in, pc_out, seg_out, sp_out, psw_out;
	logic [15:0] mem_wdata, mem_rdata, io_addr;
	logic [19:0] mem_addr;
	logic [1:0]  lat;
	logic [7:0]  dsp[4] = '{8'h80, 8'h7f, 8'h00, 8'hff};
	int          miscompares, check_count;
	stl_trap_unit #(.AW(20)) dut_u (.*);
	stl_mem_model mem_u (.*);
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s exp %h got %h", what, exp, got);
		end
	endtask
	// offer a command, then wait a bounded time for its update pulse
	task automatic run(input logic [3:0] op, input logic [7:0] imm, input logic v);
		int i;
		{cmd_op, cmd_imm, psw_in[`STL_FLAG_OVF], cmd_valid} = {op, imm, v, 1'b1};
		for (i = 0; i < 50 && cmd_ready !== 1'b1; i++)
			@(negedge clk_sys);
		if (i == 50) begin
			miscompares++;
			end_sim();
		end
		@(negedge clk_sys);
		cmd_valid = 1'b0;
		for (i = 0; i < 60 && upd_valid !== 1'b1; i++)
			@(negedge clk_sys);
		if (i == 60) begin
			miscompares++;
			end_sim();
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		logic [35:0] e;
		e = '1;
		if (mem_u.wr_log.size() > 0)
			e = mem_u.wr_log.pop_front();
		chk("push addr", a, e[31:16]);
		chk("push data", d, e[15:0]);
	endtask
	// new state from the vector, then flags, segment, pc pushed in that order
	task automatic trap(input logic [15:0] va, input logic [15:0] psw_e);
		chk("pc", va ^ 16'h5a5a, pc_out);
		chk("seg", (va + 16'h0002) ^ 16'h5a5a, seg_out);
		chk("sp", sp_in - 16'h0006, sp_out);
		chk("psw", psw_e, psw_out);
		wr(sp_in - 16'h0002, psw_in);
		wr(sp_in - 16'h0004, seg_in);
		wr(sp_in - 16'h0006, pc_in);
	endtask
	task automatic io(input logic w, input logic [7:0] d);
		{io_wr, io_rd, io_wdata} = {w, !w, d};
		@(negedge clk_sys);
		{io_wr, io_rd} = 2'b00;
		@(negedge clk_sys);
	endtask
	task automatic done_pulse(input logic rep);
		{rep_busy, instr_done} = {rep, 1'b1};
		@(negedge clk_sys);
		instr_done = 1'b0;
	endtask
	initial begin
		{resetn, cmd_valid, io_wr, io_rd, instr_done, rep_busy, small_mode, hold_req} = '0;
		{ce, cmd_op, cmd_imm, io_wdata, lat, miscompares, check_count} = {1'b1, 22'h0, 64'h0};
		{pc_in, seg_in, ss_in, sp_in, psw_in} = {16'h1000, 16'h2345, 16'h0000, 16'h0400, 16'h83d5};
		io_addr = 16'hff80;
		repeat (20) @(negedge clk_sys);
		resetn = 1'b1;
		io(1'b0, 8'h00);
		chk("mode reg reset", 16'h0000, {8'h00, io_rdata});
		chk("lock idle", 16'h0001, {15'h0, bus_lock_n});
		run(`STL_OP_TRAP_FIXED, 8'h00, 1'b0);
		trap(16'h000c, 16'h80d5);
		lat = 2'h2;
		run(`STL_OP_TRAP_IMM, 8'h40, 1'b1);
		trap(16'h0100, 16'h88d5);
		lat = 2'h1;
		run(`STL_OP_OVF_TRAP, 8'h00, 1'b1);
		trap(16'h0010, 16'h88d5);
		run(`STL_OP_OVF_TRAP, 8'h00, 1'b0);
		chk("ovf trap pc", pc_in, pc_out);
		chk("ovf trap writes", 16'h0, 16'(mem_u.wr_log.size()));
		$display("trap tests done");
		run(`STL_OP_EMU_ENTRY, 8'h20, 1'b0);
		trap(16'h0080, 16'h03d5);
		chk("emu on", 16'h1, {15'h0, emu_mode});
		run(`STL_OP_NAT_CALL, 8'h21, 1'b0);
		trap(16'h0084, 16'h83d5);
		chk("emu off", 16'h0, {15'h0, emu_mode});
		run(`STL_OP_EMU_ENTRY, 8'h20, 1'b0);
		trap(16'h0080, 16'h03d5);
		run(`STL_OP_EMU_RET, 8'h00, 1'b0);
		chk("emu return", 16'h0, {15'h0, emu_mode});
		$display("emulation tests done");
		lat = 2'h0;
		run(`STL_OP_EXT_ENTRY, 8'h0a, 1'b0);
		chk("ext pc", 16'h0028 ^ 16'h5a5a, pc_out);
		chk("ext seg", 16'h002a ^ 16'h5a5a, seg_out);
		chk("ext sp", sp_in, sp_out);
		chk("ext writes", 16'h0, 16'(mem_u.wr_log.size()));
		chk("ext normal read", 16'h0, {15'h0, mem_u.ext_q});
		io(1'b0, 8'h00);
		chk("mode reg set", 16'h0001, {8'h00, io_rdata});
		run(`STL_OP_EXT_ENTRY, 8'h0b, 1'b0);
		chk("ext wide read", 16'h1, {15'h0, mem_u.ext_q});
		run(`STL_OP_INT_RET, 8'h00, 1'b0);
		io(1'b1, 8'h00);
		chk("ext kept", 16'h1, {15'h0, ext_addr_mode});
		run(`STL_OP_EXT_RET, 8'h00, 1'b0);
		chk("ext cleared", 16'h0, {15'h0, ext_addr_mode});
		$display("extended mode tests done");
		// no lock ahead of test-wait instruction
		run(`STL_OP_LOCK, 8'h00, 1'b0);
		chk("locked", 16'h0, {15'h0, bus_lock_n});
		chk("inhibit", 16'h1, {15'h0, int_inhibit});
		done_pulse(1'b1);
		chk("lock in repeat", 16'h0, {15'h0, bus_lock_n});
		done_pulse(1'b0);
		chk("unlocked", 16'h1, {15'h0, bus_lock_n});
		{small_mode, hold_req} = 2'b11;
		run(`STL_OP_LOCK, 8'h00, 1'b0);
		chk("hold refused", 16'h0, {15'h0, hold_grant});
		chk("no lock pin", 16'h1, {15'h0, bus_lock_n});
		done_pulse(1'b0);
		chk("hold back", 16'h1, {15'h0, hold_grant});
		$display("lock tests done");
		foreach (dsp[k]) begin
			run(`STL_OP_OVF_BRANCH, dsp[k], k[0] == 1'b0);
			chk("ovf branch pc", k[0] ? pc_in : pc_in + {{8{dsp[k][7]}}, dsp[k]}, pc_out);
			chk("ovf branch flags", psw_in, psw_out);
		end
		$display("branch tests done");
		end_sim();
	end
endmodule
bind stl_trap_unit stl_trap_unit_assertions chk_u (.*);
